//--- hdl/ufc_pkg.sv
// shared constants and types for the serial port with rts/cts flow control
package ufc_pkg;
    // register port geometry
    localparam int ADDR_W = 3;
    localparam int REG_W = 8;
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_STAT = 3'h1;
    localparam logic [2:0] ADDR_CTRL = 3'h2;
    localparam logic [2:0] ADDR_FMT = 3'h3;
    localparam logic [2:0] ADDR_FLOW = 3'h4;
    localparam logic [2:0] ADDR_BAUD_LO = 3'h5;
    localparam logic [2:0] ADDR_BAUD_HI = 3'h6;
    // line_status_control bits
    localparam int STAT_TXC = 6;
    localparam int STAT_U2X = 1;
    localparam int STAT_MPCM = 0;
    localparam logic [7:0] STAT_RESET = 8'h20;
    // irq_enable_control bits
    localparam int CTRL_RXCIE = 7;
    localparam int CTRL_TXCIE = 6;
    localparam int CTRL_UDRIE = 5;
    localparam int CTRL_RXEN = 4;
    localparam int CTRL_TXEN = 3;
    localparam int CTRL_CSZ2 = 2;
    localparam int CTRL_TXB8 = 0;
    // frame_format_control fields
    localparam int FMT_MODE_LO = 6;
    localparam int FMT_PM_LO = 4;
    localparam int FMT_SBS = 3;
    localparam int FMT_CSZ_LO = 1;
    localparam int FMT_POL = 0;
    // flow_control_register bits
    localparam int FLOW_CTS = 1;
    localparam int FLOW_RTS = 0;
    // codes
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [2:0] CSZ_9BIT = 3'h7;
    // receive entry layout: parity error, frame error, nine data bits
    localparam int DATA_W = 9;
    localparam int ENTRY_W = 11;
    localparam int ENT_PE = 10;
    localparam int ENT_FE = 9;
    // oversampling: ticks per bit and the 2/3 point of the stop bit
    localparam int OVS_NORMAL = 16;
    localparam int OVS_DOUBLE = 8;
    localparam int RTS_NUM = 2;
    localparam int RTS_DEN = 3;
    localparam logic [3:0] TICK_LAST_N = 4'(OVS_NORMAL - 1);
    localparam logic [3:0] TICK_LAST_D = 4'(OVS_DOUBLE - 1);
    localparam logic [3:0] TICK_MID_N = 4'(OVS_NORMAL / 2 - 1);
    localparam logic [3:0] TICK_MID_D = 4'(OVS_DOUBLE / 2 - 1);
    localparam logic [3:0] TICK_RTS_N = 4'(OVS_NORMAL * RTS_NUM / RTS_DEN);
    localparam logic [3:0] TICK_RTS_D = 4'(OVS_DOUBLE * RTS_NUM / RTS_DEN);
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ufc_tx_state_type;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ufc_rx_state_type;
endpackage

//--- hdl/ufc_fifo_if.sv
// signals between the serial core and its receive queue
`timescale 1ns/1ps
`default_nettype none
interface ufc_fifo_if #(
    parameter int W = 11,
    parameter int CW = 2
);
    logic push;
    logic pop;
    logic flush;
    logic [W-1:0] wdata;
    logic [W-1:0] head;
    logic [CW-1:0] count;
    modport producer(output push, output pop, output flush, output wdata, input head, input count);
    modport store(input push, input pop, input flush, input wdata, output head, output count);
endinterface
`default_nettype wire

//--- hdl/ufc_rx_fifo.sv
// shifting receive queue; the head entry is always a register
`timescale 1ns/1ps
`default_nettype none
module ufc_rx_fifo #(
    parameter int W = 11,
    parameter int DEPTH = 2,
    parameter int CW = 2
) (
    // clock and control
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clk_en,
    // queue port
    ufc_fifo_if.store q
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [CW-1:0] count;
    } ufc_fifo_state_type;

    ufc_fifo_state_type st_ff;
    ufc_fifo_state_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (q.flush) begin
            nxt_st.count = '0;
        end else begin
            // pop first so a push in the same cycle lands behind the survivors
            if (q.pop && st_ff.count != '0) begin
                for (int i = 0; i < DEPTH - 1; i++) begin
                    nxt_st.mem[i] = st_ff.mem[i + 1];
                end
                nxt_st.count = st_ff.count - CW'(1);
            end
            if (q.push && nxt_st.count < CW'(DEPTH)) begin
                nxt_st.mem[nxt_st.count] = q.wdata;
                nxt_st.count = nxt_st.count + CW'(1);
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            st_ff <= '0;
        end else if (i_clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign q.head = st_ff.mem[0];
    assign q.count = st_ff.count;
endmodule
`default_nettype wire

//--- hdl/ufc_uart.sv
// serial port core: registers, transmitter, receiver, rts/cts flow control
`timescale 1ns/1ps
`default_nettype none
module ufc_uart #(
    parameter int FIFO_DEPTH = 2
) (
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clk_en,
    // register port
    input wire logic [ufc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [ufc_pkg::REG_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [ufc_pkg::REG_W-1:0] o_rdata,
    // cpu interrupt gating
    input wire logic i_global_irq_enable,
    input wire logic i_tx_irq_ack,
    output logic o_rxc_irq,
    output logic o_txc_irq,
    output logic o_udre_irq,
    // serial pins
    input wire logic i_serial_in,
    output logic o_serial_in_en,
    output logic o_serial_out,
    output logic o_serial_out_en,
    input wire logic i_cts_n,
    output logic o_rts_n
);
    import ufc_pkg::*;

    localparam int CW = $clog2(FIFO_DEPTH + 1);

    typedef struct packed {
        logic [1:0] rxd_sync;
        logic [1:0] cts_sync;
        logic [7:0] rdata;
        logic [11:0] baud_div;
        logic [11:0] baud_cnt;
        logic txc;
        logic dor;
        logic u2x;
        logic mpcm;
        logic rxcie;
        logic txcie;
        logic udrie;
        logic rxen;
        logic txen;
        logic csz2;
        logic txb8;
        logic [1:0] mode;
        logic [1:0] pm;
        logic sbs;
        logic [1:0] csz_lo;
        logic pol;
        logic cts_en;
        logic rts_en;
        ufc_tx_state_type tx_st;
        logic [3:0] tx_tick;
        logic [3:0] tx_bit;
        logic [8:0] tx_buf;
        logic tx_buf_full;
        logic [8:0] tx_sh;
        logic tx_par;
        logic tx_space;
        logic tx_drive;
        logic cts_hold;
        ufc_rx_state_type rx_st;
        logic [3:0] rx_tick;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        logic rx_par_bad;
        logic [ENTRY_W-1:0] hold;
        logic hold_valid;
        logic rts;
    } ufc_core_state_type;

    ufc_core_state_type st_ff;
    ufc_core_state_type nxt_st;

    function automatic logic [3:0] char_bits(input logic [2:0] code);
        case (code)
            3'h0: char_bits = 4'h5;
            3'h1: char_bits = 4'h6;
            3'h2: char_bits = 4'h7;
            CSZ_9BIT: char_bits = 4'h9;
            default: char_bits = 4'h8;
        endcase
    endfunction

    function automatic logic data_parity(input logic [8:0] d, input logic [3:0] n);
        data_parity = 1'b0;
        for (int i = 0; i < DATA_W; i++) begin
            if (4'(i) < n) begin
                data_parity = data_parity ^ d[i];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // receive queue

    ufc_fifo_if #(.W(ENTRY_W), .CW(CW)) rxq ();

    ufc_rx_fifo #(.W(ENTRY_W), .DEPTH(FIFO_DEPTH), .CW(CW)) u_rxq (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_clk_en(i_clk_en),
        .q(rxq.store)
    );

    logic rxd;
    logic cts;
    logic fast;
    logic nine;
    logic baud_tick;
    logic data_wr;
    logic data_rd;
    logic rxq_full;
    logic rxc;
    logic rx_pop;
    logic drain;
    logic [3:0] nbits;
    logic [3:0] tick_last;
    logic [3:0] tick_mid;
    logic [3:0] tick_rts;
    logic [7:0] stat_rd;
    logic [7:0] ctrl_rd;
    logic [7:0] fmt_rd;

    // only the second synchroniser stage is ever looked at
    assign rxd = st_ff.rxd_sync[1];
    assign cts = st_ff.cts_sync[1];
    assign fast = st_ff.u2x && st_ff.mode == MODE_ASYNC;
    assign tick_last = fast ? TICK_LAST_D : TICK_LAST_N;
    assign tick_mid = fast ? TICK_MID_D : TICK_MID_N;
    assign tick_rts = fast ? TICK_RTS_D : TICK_RTS_N;
    assign nbits = char_bits({st_ff.csz2, st_ff.csz_lo});
    assign nine = {st_ff.csz2, st_ff.csz_lo} == CSZ_9BIT;
    assign baud_tick = st_ff.baud_cnt == 12'h000;
    assign data_wr = i_wr && i_addr == ADDR_DATA;
    assign data_rd = i_rd && i_addr == ADDR_DATA;
    assign rxq_full = rxq.count == CW'(FIFO_DEPTH);
    assign rxc = st_ff.rxen && rxq.count != '0;
    assign rx_pop = data_rd && rxc;
    // the waiting character moves up as soon as the queue has room
    assign drain = st_ff.hold_valid && (!rxq_full || rx_pop);

    assign rxq.push = drain;
    assign rxq.pop = rx_pop;
    assign rxq.flush = !st_ff.rxen;
    assign rxq.wdata = st_ff.hold;

    // flags of the head entry are only meaningful while it is unread
    assign stat_rd = {rxc, st_ff.txc, !st_ff.tx_buf_full, rxc && rxq.head[ENT_FE],
                      st_ff.dor, rxc && rxq.head[ENT_PE], st_ff.u2x, st_ff.mpcm};
    assign ctrl_rd = {st_ff.rxcie, st_ff.txcie, st_ff.udrie, st_ff.rxen, st_ff.txen,
                      st_ff.csz2, rxc && rxq.head[8], st_ff.txb8};
    assign fmt_rd = {st_ff.mode, st_ff.pm, st_ff.sbs, st_ff.csz_lo, st_ff.pol};

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rxd_sync = {st_ff.rxd_sync[0], i_serial_in};
        nxt_st.cts_sync = {st_ff.cts_sync[0], i_cts_n};
        nxt_st.baud_cnt = baud_tick ? st_ff.baud_div : st_ff.baud_cnt - 12'h001;

        // register writes
        if (i_wr) begin
            case (i_addr)
                ADDR_STAT: begin
                    nxt_st.u2x = i_wdata[STAT_U2X];
                    nxt_st.mpcm = i_wdata[STAT_MPCM];
                    if (i_wdata[STAT_TXC]) begin
                        nxt_st.txc = 1'b0;
                    end
                end
                ADDR_CTRL: begin
                    nxt_st.rxcie = i_wdata[CTRL_RXCIE];
                    nxt_st.txcie = i_wdata[CTRL_TXCIE];
                    nxt_st.udrie = i_wdata[CTRL_UDRIE];
                    nxt_st.rxen = i_wdata[CTRL_RXEN];
                    nxt_st.txen = i_wdata[CTRL_TXEN];
                    nxt_st.csz2 = i_wdata[CTRL_CSZ2];
                    nxt_st.txb8 = i_wdata[CTRL_TXB8];
                end
                ADDR_FMT: begin
                    nxt_st.mode = i_wdata[FMT_MODE_LO +: 2];
                    nxt_st.pm = i_wdata[FMT_PM_LO +: 2];
                    nxt_st.sbs = i_wdata[FMT_SBS];
                    nxt_st.csz_lo = i_wdata[FMT_CSZ_LO +: 2];
                    nxt_st.pol = i_wdata[FMT_POL];
                end
                ADDR_FLOW: begin
                    nxt_st.cts_en = i_wdata[FLOW_CTS];
                    nxt_st.rts_en = i_wdata[FLOW_RTS];
                end
                ADDR_BAUD_LO: begin
                    // writing the low byte restarts the prescaler at once
                    nxt_st.baud_div[7:0] = i_wdata;
                    nxt_st.baud_cnt = {st_ff.baud_div[11:8], i_wdata};
                end
                ADDR_BAUD_HI: begin
                    nxt_st.baud_div[11:8] = i_wdata[3:0];
                end
                default: begin
                end
            endcase
        end
        if (i_tx_irq_ack) begin
            nxt_st.txc = 1'b0;
        end

        // register reads, data one cycle later
        nxt_st.rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                ADDR_DATA: nxt_st.rdata = rxc ? rxq.head[7:0] : 8'h00;
                ADDR_STAT: nxt_st.rdata = stat_rd;
                ADDR_CTRL: nxt_st.rdata = ctrl_rd;
                ADDR_FMT: nxt_st.rdata = fmt_rd;
                ADDR_FLOW: nxt_st.rdata = {6'h00, st_ff.cts_en, st_ff.rts_en};
                ADDR_BAUD_LO: nxt_st.rdata = st_ff.baud_div[7:0];
                ADDR_BAUD_HI: nxt_st.rdata = {4'h0, st_ff.baud_div[11:8]};
                default: nxt_st.rdata = 8'h00;
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // transmitter

        if (data_wr) begin
            nxt_st.cts_hold = cts;
            if (!st_ff.tx_buf_full) begin
                nxt_st.tx_buf = {st_ff.txb8, i_wdata};
                nxt_st.tx_buf_full = 1'b1;
            end
        end
        if (st_ff.tx_st == TX_IDLE) begin
            if (st_ff.tx_buf_full && st_ff.txen) begin
                if (st_ff.cts_en && st_ff.cts_hold) begin
                    // withheld: keep watching cts, otherwise nothing would restart us
                    nxt_st.cts_hold = cts;
                end else begin
                    nxt_st.tx_sh = st_ff.tx_buf;
                    nxt_st.tx_par = data_parity(st_ff.tx_buf, nbits) ^ st_ff.pm[0];
                    nxt_st.tx_buf_full = 1'b0;
                    nxt_st.tx_st = TX_START;
                    nxt_st.tx_tick = 4'h0;
                    nxt_st.tx_space = 1'b1;
                end
            end
        end else if (baud_tick) begin
            nxt_st.tx_tick = st_ff.tx_tick + 4'h1;
            if (st_ff.tx_st == TX_STOP && st_ff.tx_bit == {3'h0, st_ff.sbs}
                    && st_ff.tx_tick == tick_mid) begin
                nxt_st.cts_hold = cts;
            end
            if (st_ff.tx_tick == tick_last) begin
                nxt_st.tx_tick = 4'h0;
                case (st_ff.tx_st)
                    TX_START: begin
                        nxt_st.tx_st = TX_DATA;
                        nxt_st.tx_bit = 4'h0;
                        nxt_st.tx_space = !st_ff.tx_sh[0];
                        nxt_st.tx_sh = st_ff.tx_sh >> 1;
                    end
                    TX_DATA: begin
                        // bits above the character size are never shifted out
                        if (st_ff.tx_bit == nbits - 4'h1) begin
                            nxt_st.tx_bit = 4'h0;
                            if (st_ff.pm[1]) begin
                                nxt_st.tx_st = TX_PARITY;
                                nxt_st.tx_space = !st_ff.tx_par;
                            end else begin
                                nxt_st.tx_st = TX_STOP;
                                nxt_st.tx_space = 1'b0;
                            end
                        end else begin
                            nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
                            nxt_st.tx_space = !st_ff.tx_sh[0];
                            nxt_st.tx_sh = st_ff.tx_sh >> 1;
                        end
                    end
                    TX_PARITY: begin
                        nxt_st.tx_st = TX_STOP;
                        nxt_st.tx_space = 1'b0;
                    end
                    TX_STOP: begin
                        if (st_ff.sbs && st_ff.tx_bit == 4'h0) begin
                            nxt_st.tx_bit = 4'h1;
                        end else begin
                            nxt_st.tx_st = TX_IDLE;
                            if (!st_ff.tx_buf_full) begin
                                nxt_st.txc = 1'b1;
                            end
                        end
                    end
                    default: begin
                        nxt_st.tx_st = TX_IDLE;
                        nxt_st.tx_space = 1'b0;
                    end
                endcase
            end
        end
        nxt_st.tx_drive = nxt_st.txen || nxt_st.tx_st != TX_IDLE || nxt_st.tx_buf_full;

        ////////////////////////////////////////////////////////////////////////
        // receiver

        if (drain) begin
            nxt_st.hold_valid = 1'b0;
        end
        if (data_rd) begin
            nxt_st.dor = 1'b0;
        end
        if (!st_ff.rts_en || !rxq_full) begin
            nxt_st.rts = 1'b0;
        end
        if (!st_ff.rxen) begin
            nxt_st.rx_st = RX_IDLE;
            nxt_st.hold_valid = 1'b0;
            nxt_st.dor = 1'b0;
        end else if (st_ff.rx_st == RX_IDLE) begin
            if (!rxd) begin
                nxt_st.rx_st = RX_START;
                nxt_st.rx_tick = 4'h0;
                nxt_st.rx_sh = 9'h000;
                nxt_st.rx_par_bad = 1'b0;
                if (rxq_full && st_ff.hold_valid) begin
                    nxt_st.dor = 1'b1;
                end
            end
        end else if (baud_tick) begin
            nxt_st.rx_tick = (st_ff.rx_tick == tick_last) ? 4'h0 : st_ff.rx_tick + 4'h1;
            case (st_ff.rx_st)
                RX_START: begin
                    if (st_ff.rx_tick == tick_mid && rxd) begin
                        nxt_st.rx_st = RX_IDLE;
                    end else if (st_ff.rx_tick == tick_last) begin
                        nxt_st.rx_st = RX_DATA;
                        nxt_st.rx_bit = 4'h0;
                    end
                end
                RX_DATA: begin
                    if (st_ff.rx_tick == tick_mid) begin
                        nxt_st.rx_sh[st_ff.rx_bit] = rxd;
                    end
                    if (st_ff.rx_tick == tick_last) begin
                        if (st_ff.rx_bit == nbits - 4'h1) begin
                            nxt_st.rx_st = st_ff.pm[1] ? RX_PARITY : RX_STOP;
                        end else begin
                            nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
                        end
                    end
                end
                RX_PARITY: begin
                    if (st_ff.rx_tick == tick_mid) begin
                        nxt_st.rx_par_bad = (^st_ff.rx_sh ^ rxd) != st_ff.pm[0];
                    end
                    if (st_ff.rx_tick == tick_last) begin
                        nxt_st.rx_st = RX_STOP;
                    end
                end
                RX_STOP: begin
                    // only the first stop bit is examined, the stop setting is ignored
                    if (st_ff.rx_tick == tick_mid) begin
                        if (!(st_ff.mpcm && !(nine ? st_ff.rx_sh[8] : rxd))) begin
                            if (!st_ff.hold_valid || drain) begin
                                nxt_st.hold = {st_ff.rx_par_bad && st_ff.pm[1], !rxd,
                                               st_ff.rx_sh};
                                nxt_st.hold_valid = 1'b1;
                            end
                        end
                    end
                    if (st_ff.rx_tick == tick_rts) begin
                        if (st_ff.rts_en && rxq_full) begin
                            nxt_st.rts = 1'b1;
                        end
                        nxt_st.rx_st = RX_IDLE;
                    end
                end
                default: begin
                    nxt_st.rx_st = RX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register and outputs

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            st_ff <= '0;
        end else if (i_clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign o_rdata = st_ff.rdata;
    assign o_rxc_irq = st_ff.rxcie && i_global_irq_enable && rxc;
    assign o_txc_irq = st_ff.txcie && i_global_irq_enable && st_ff.txc;
    assign o_udre_irq = st_ff.udrie && i_global_irq_enable && !st_ff.tx_buf_full;
    assign o_serial_in_en = st_ff.rxen;
    assign o_serial_out = !st_ff.tx_space;
    assign o_serial_out_en = st_ff.tx_drive;
    assign o_rts_n = st_ff.rts;
endmodule
`default_nettype wire

//--- sim/ufc_uart_sva.sv
// pin and register-port assertions for the serial port
`timescale 1ns/1ps
`default_nettype none
module ufc_uart_sva (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // register port and irq
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [ufc_pkg::REG_W-1:0] o_rdata,
    input wire logic i_global_irq_enable,
    input wire logic o_rxc_irq,
    input wire logic o_txc_irq,
    input wire logic o_udre_irq,
    // pins
    input wire logic i_serial_in,
    input wire logic o_serial_in_en,
    input wire logic o_serial_out,
    input wire logic o_serial_out_en,
    input wire logic o_rts_n
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    // a bit cell lasts at least 8 clocks: double speed with the divider at zero
    sequence low_cell;
        !o_serial_out [*8];
    endsequence
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("rdata not idle");
    rxc_gate_a: assert property (o_rxc_irq |-> i_global_irq_enable)
        else $error("rxc irq ungated");
    txc_gate_a: assert property (o_txc_irq |-> i_global_irq_enable)
        else $error("txc irq ungated");
    udre_gate_a: assert property (o_udre_irq |-> i_global_irq_enable)
        else $error("udre ungated");
    bit_width_a: assert property ($fell(o_serial_out) |-> low_cell)
        else $error("short low cell");
    tx_release_a: assert property (!o_serial_out_en |-> o_serial_out)
        else $error("tx not idle");
    rx_owner_a: assert property ($changed(o_serial_in_en)
        |-> $past(i_wr) || $past(i_wr, 2)) else $error("rx owner moved alone");
    rts_stop_a: assert property ($rose(o_rts_n) |-> $past(i_serial_in, 3))
        else $error("rts off stop");
endmodule
bind ufc_uart ufc_uart_sva ufc_uart_sva_inst (.i_clock(i_clock), .i_srst(i_srst), .i_rd(i_rd),
    .i_wr(i_wr), .o_rdata(o_rdata), .i_global_irq_enable(i_global_irq_enable),
    .o_rxc_irq(o_rxc_irq), .o_txc_irq(o_txc_irq), .o_udre_irq(o_udre_irq),
    .i_serial_in(i_serial_in), .o_serial_in_en(o_serial_in_en), .o_serial_out(o_serial_out),
    .o_serial_out_en(o_serial_out_en), .o_rts_n(o_rts_n));
`default_nettype wire

//--- sim/ufc_link_partner.sv
// far station: echoes our line back and is paced by our rts
`timescale 1ns/1ps
`default_nettype none
module ufc_link_partner (
    input wire logic i_tx,
    input wire logic i_tx_en,
    input wire logic i_rts_n,
    output logic o_rx,
    output logic o_cts_n
);
    // a released line sits at mark through its pull-up
    assign o_rx = i_tx_en ? i_tx : 1'b1;
    // its receiver is our queue, so our stop request gates our sender
    assign o_cts_n = i_rts_n;
endmodule
`default_nettype wire

//--- sim/tb.sv
// bench: looped-back traffic with rts/cts pacing and flag checks
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ufc_pkg::*;
    logic i_clock = 1'b0;
    logic i_srst = 1'b1;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [REG_W-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_global_irq_enable = 1'b0;
    logic i_tx_irq_ack = 1'b0;
    logic [REG_W-1:0] o_rdata;
    logic o_rxc_irq, o_txc_irq, o_udre_irq, rx_line, o_serial_in_en, o_serial_out;
    logic o_serial_out_en, cts_n, o_rts_n, seen_low;
    int n_errors = 0;
    int n_compared = 0;
    always #12.5 i_clock = ~i_clock;
    ufc_uart ufc_uart_inst (.i_clock(i_clock), .i_srst(i_srst), .i_clk_en(1'b1), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_global_irq_enable(i_global_irq_enable), .i_tx_irq_ack(i_tx_irq_ack),
        .o_rxc_irq(o_rxc_irq),
        .o_txc_irq(o_txc_irq), .o_udre_irq(o_udre_irq), .i_serial_in(rx_line),
        .o_serial_in_en(o_serial_in_en), .o_serial_out(o_serial_out),
        .o_serial_out_en(o_serial_out_en), .i_cts_n(cts_n), .o_rts_n(o_rts_n));
    ufc_link_partner ufc_link_partner_inst (.i_tx(o_serial_out), .i_tx_en(o_serial_out_en),
        .i_rts_n(o_rts_n), .o_rx(rx_line), .o_cts_n(cts_n));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // a clock is left between strobes so no strobe is driven twice in one step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] exp, input string what);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 check(what, o_rdata, exp);
        @(posedge i_clock);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_reset();
        rc(ADDR_STAT, 8'h20, "status at reset");
        rc(ADDR_CTRL, 8'h00, "ctrl at reset");
        check("rts at reset", {7'h0, o_rts_n}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_flow();
        wr(ADDR_FMT, 8'h06);
        wr(ADDR_FLOW, 8'h03);
        wr(ADDR_CTRL, 8'h18);
        wr(ADDR_DATA, 8'h11);
        repeat (5) @(posedge i_clock);
        wr(ADDR_DATA, 8'h22);
        wr(ADDR_DATA, 8'h33);
        repeat (600) if (!o_rts_n) @(posedge i_clock);
        check("rts on full queue", {7'h0, o_rts_n}, 8'h01);
        repeat (40) @(posedge i_clock);
        rc(ADDR_STAT, 8'hE0, "status queue full");
        wr(ADDR_DATA, 8'h44);
        seen_low = 1'b0;
        repeat (300) begin
            @(posedge i_clock);
            seen_low |= !o_serial_out;
        end
        check("withheld by cts", {7'h0, seen_low}, 8'h00);
        rc(ADDR_DATA, 8'h11, "first entry");
        rc(ADDR_DATA, 8'h22, "second entry");
        repeat (250) @(posedge i_clock);
        $display("test flow done");
    endtask
    task automatic t_flags();
        i_global_irq_enable <= 1'b1;
        wr(ADDR_CTRL, 8'hB8);
        check("irq lines", {5'h0, o_rxc_irq, o_txc_irq, o_udre_irq}, 8'h05);
        i_global_irq_enable <= 1'b0;
        @(posedge i_clock);
        #1 check("irq masked", {5'h0, o_rxc_irq, o_txc_irq, o_udre_irq}, 8'h00);
        wr(ADDR_CTRL, 8'h08);
        rc(ADDR_STAT, 8'h60, "status rx off");
        check("rx pin released", {7'h0, o_serial_in_en}, 8'h00);
        wr(ADDR_STAT, 8'h40);
        rc(ADDR_STAT, 8'h20, "txc cleared");
        $display("test flags done");
    endtask
    // transmitter switched off mid frame, then txc cleared by the interrupt acknowledge
    task automatic t_ack();
        wr(ADDR_DATA, 8'h55);
        wr(ADDR_CTRL, 8'h00);
        check("tx kept while busy", {7'h0, o_serial_out_en}, 8'h01);
        repeat (200) @(posedge i_clock);
        check("tx pin released", {7'h0, o_serial_out_en}, 8'h00);
        rc(ADDR_STAT, 8'h60, "txc after frame");
        i_tx_irq_ack <= 1'b1;
        @(posedge i_clock);
        i_tx_irq_ack <= 1'b0;
        rc(ADDR_STAT, 8'h20, "txc cleared by ack");
        $display("test ack done");
    endtask
    initial begin
        repeat (10) @(posedge i_clock);
        i_srst <= 1'b0;
        @(posedge i_clock);
        t_reset();
        t_flow();
        t_flags();
        t_ack();
        print_verdict();
    end
    // whole run is about 1200 clocks
    initial begin
        #(25 * 20000);
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
